// ===== rtl/iscaa_pkg.sv
// Shared constants, types and helpers of the two-wire slave block
package iscaa_pkg;

  // Slave mode field encodings: bit 0 selects 10-bit, bit 1 adds Start/Stop interrupts
  localparam logic [1:0] MODE_7BIT       = 2'h0;
  localparam logic [1:0] MODE_10BIT      = 2'h1;
  localparam logic [1:0] MODE_7BIT_SP    = 2'h2;
  localparam logic [1:0] MODE_10BIT_SP   = 2'h3;

  localparam logic [4:0] ADDR10_PREFIX   = 5'h1e;
  localparam logic [7:0] RW_IGNORE_MASK  = 8'hfe;
  localparam logic [7:0] ADDR_RESET      = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'hff;
  localparam logic [3:0] ACK_BIT_COUNT   = 4'h8;
  localparam logic [3:0] BYTE_END_COUNT  = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_RX,
    ST_TX_WAIT,
    ST_TX
  } iscaa_state_t;

  // Quasi-static settings carried into the link domain
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] addr;
    logic [7:0] addr_lo;
    logic [7:0] mask;
    logic       addr_hold;
    logic       data_hold;
    logic       ack_data;
    logic       buf_full;
    logic       overflow;
  } iscaa_cfg_t;

  // One-shot events from the link domain
  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
    logic rx_byte;
    logic tx_req;
    logic collision;
  } iscaa_ev_t;

  // Levels from the link domain
  typedef struct packed {
    logic ack_time;
    logic ack_rcvd;
    logic idle;
    logic prior_match;
    logic read_mode;
  } iscaa_stat_t;

  function automatic logic is_ten_bit(input logic [1:0] mode);
    return mode[0];
  endfunction

  function automatic logic has_sp_irq(input logic [1:0] mode);
    return mode[1];
  endfunction

  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] ref_val,
                                      input logic [7:0] mask);
    return ((rx ^ ref_val) & mask) == 8'h00;
  endfunction

endpackage

// ===== rtl/iscaa_pulse_sync.sv
// Toggle-based event crossing, one lane per bit
`timescale 1ns/100ps
module iscaa_pulse_sync
  import iscaa_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             src_clk_i,
  input  wire logic             src_rst_i,
  input  wire logic [WIDTH-1:0] src_pulse_i,
  input  wire logic             dst_clk_i,
  input  wire logic             dst_rst_i,
  output logic      [WIDTH-1:0] dst_pulse_o
);

  logic [WIDTH-1:0] tog_ff;
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] seen_ff;

  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      tog_ff <= '0;
    end else begin
      tog_ff <= tog_ff ^ src_pulse_i;
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      seen_ff <= '0;
    end else begin
      meta_ff <= tog_ff;
      sync_ff <= meta_ff;
      seen_ff <= sync_ff;
    end
  end

  assign dst_pulse_o = sync_ff ^ seen_ff;

endmodule

// ===== rtl/iscaa_slave.sv
// Two-wire slave: bus conditions, acknowledge and address matching
`timescale 1ns/100ps
module iscaa_slave
  import iscaa_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic       SRST_I,
  input  wire logic       LINK_CLK_I,
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE_O,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  input  wire logic [1:0] PORT_MODE_SELECT_I,
  input  wire logic [7:0] SLAVE_ADDRESS_I,
  input  wire logic [7:0] SLAVE_ADDRESS_LOW_I,
  input  wire logic [7:0] ADDRESS_MASK_I,
  input  wire logic       START_IRQ_ENABLE_I,
  input  wire logic       STOP_IRQ_ENABLE_I,
  input  wire logic       ADDRESS_HOLD_ENABLE_I,
  input  wire logic       DATA_HOLD_ENABLE_I,
  input  wire logic       ACK_DATA_VALUE_I,
  input  wire logic       RELEASE_CLOCK_I,
  input  wire logic       TX_LOAD_I,
  input  wire logic [7:0] TX_DATA_I,
  input  wire logic       BUFFER_READ_I,
  input  wire logic       IRQ_FLAG_CLEAR_I,
  input  wire logic       OVERFLOW_CLEAR_I,
  input  wire logic       COLLISION_CLEAR_I,
  output logic [7:0]      RECEIVE_BUFFER_O,
  output logic            BUFFER_FULL_FLAG_O,
  output logic            RECEIVE_OVERFLOW_FLAG_O,
  output logic            PORT_INTERRUPT_FLAG_O,
  output logic            BUS_COLLISION_O,
  output logic            START_SEEN_O,
  output logic            STOP_SEEN_O,
  output logic            ACK_RECEIVED_STATUS_O,
  output logic            ACK_TIME_STATUS_O,
  output logic            BUS_IDLE_O,
  output logic            PRIOR_MATCH_O,
  output logic            READ_NOT_WRITE_O
);

  // ---------------- Crossings ----------------
  logic         link_rst;
  logic [1:0]   pin_s;
  iscaa_cfg_t   cfg_c;
  iscaa_cfg_t   cfg_l;
  iscaa_ev_t    ev_ff;
  iscaa_ev_t    ev_c;
  iscaa_stat_t  stat_l;
  iscaa_stat_t  stat_c;
  logic [1:0]   cmd_l;
  logic [7:0]   tx_data_ff;
  logic         bf_ff;
  logic         ov_ff;

  assign cfg_c = '{mode:      PORT_MODE_SELECT_I,
                   addr:      SLAVE_ADDRESS_I,
                   addr_lo:   SLAVE_ADDRESS_LOW_I,
                   mask:      ADDRESS_MASK_I,
                   addr_hold: ADDRESS_HOLD_ENABLE_I,
                   data_hold: DATA_HOLD_ENABLE_I,
                   ack_data:  ACK_DATA_VALUE_I,
                   buf_full:  bf_ff,
                   overflow:  ov_ff};

  iscaa_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk_i (LINK_CLK_I),
    .rst_i (1'b0),
    .d_i   (SRST_I),
    .q_o   (link_rst)
  );

  iscaa_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk_i (LINK_CLK_I),
    .rst_i (link_rst),
    .d_i   ({SCL_I, SDA_I}),
    .q_o   (pin_s)
  );

  iscaa_sync #(.WIDTH($bits(iscaa_cfg_t))) u_cfg_sync (
    .clk_i (LINK_CLK_I),
    .rst_i (link_rst),
    .d_i   (cfg_c),
    .q_o   (cfg_l)
  );

  iscaa_sync #(.WIDTH($bits(iscaa_stat_t))) u_stat_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (SRST_I),
    .d_i   (stat_l),
    .q_o   (stat_c)
  );

  iscaa_pulse_sync #(.WIDTH(2)) u_cmd_sync (
    .src_clk_i   (CORE_CLK_I),
    .src_rst_i   (SRST_I),
    .src_pulse_i ({RELEASE_CLOCK_I, TX_LOAD_I}),
    .dst_clk_i   (LINK_CLK_I),
    .dst_rst_i   (link_rst),
    .dst_pulse_o (cmd_l)
  );

  iscaa_pulse_sync #(.WIDTH($bits(iscaa_ev_t))) u_ev_sync (
    .src_clk_i   (LINK_CLK_I),
    .src_rst_i   (link_rst),
    .src_pulse_i (ev_ff),
    .dst_clk_i   (CORE_CLK_I),
    .dst_rst_i   (SRST_I),
    .dst_pulse_o (ev_c)
  );

  // ---------------- Link domain: bus conditions ----------------
  logic scl_s;
  logic sda_s;
  logic scl_q_ff;
  logic sda_q_ff;
  logic busy_ff;
  logic saw_low_ff;
  logic idle_ff;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_ff @(posedge LINK_CLK_I) begin
    if (link_rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign start_det = scl_q_ff & scl_s & sda_q_ff & ~sda_s;
  // Stop edge, only after a clock-low interval
  assign stop_det  = scl_q_ff & scl_s & ~sda_q_ff & sda_s & saw_low_ff;
  assign scl_rise  = ~scl_q_ff & scl_s;
  assign scl_fall  = scl_q_ff & ~scl_s;

  always_ff @(posedge LINK_CLK_I) begin
    if (link_rst) begin
      busy_ff    <= 1'b0;
      saw_low_ff <= 1'b0;
      idle_ff    <= 1'b0;
    end else begin
      if (start_det) begin
        busy_ff <= 1'b1;
      end else if (stop_det) begin
        busy_ff <= 1'b0;
      end
      if (start_det || stop_det) begin
        saw_low_ff <= 1'b0;
      end else if (!scl_s) begin
        saw_low_ff <= 1'b1;
      end
      idle_ff <= ~busy_ff & ~start_det & scl_s & sda_s;
    end
  end

  // ---------------- Link domain: byte engine ----------------
  iscaa_state_t state_ff;
  iscaa_state_t next_ff;
  iscaa_state_t after_st;
  logic [3:0]   bit_cnt_ff;
  logic [7:0]   shift_ff;
  logic [7:0]   rx_hold_ff;
  logic [7:0]   ref_hi;
  logic         sda_oe_ff;
  logic         scl_oe_ff;
  logic         hold_ff;
  logic         nack_ff;
  logic         prior_ff;
  logic         rw_ff;
  logic         ack_rcvd_ff;
  logic         ack_time_ff;
  logic         ten;
  logic         hi_ok;
  logic         lo_ok;
  logic         accept;
  logic         forced_nack;
  logic         hold_now;

  assign ten = is_ten_bit(cfg_l.mode);
  // High byte pattern, 7-bit form ignores the lowest bit
  assign ref_hi = ten ? {ADDR10_PREFIX, cfg_l.addr[2:1], 1'b0} : cfg_l.addr;
  assign hi_ok  = addr_match(shift_ff, ref_hi, cfg_l.mask & RW_IGNORE_MASK);
  assign lo_ok  = addr_match(shift_ff, cfg_l.addr_lo, cfg_l.mask);
  assign forced_nack = cfg_l.buf_full | cfg_l.overflow;
  assign hold_now    = (state_ff == ST_RX) ? cfg_l.data_hold : cfg_l.addr_hold;

  always_comb begin
    accept   = 1'b0;
    after_st = ST_IDLE;
    case (state_ff)
      ST_ADDR_HI: begin
        if (hi_ok && !ten) begin
          accept   = 1'b1;
          after_st = shift_ff[0] ? ST_TX : ST_RX;
        end else if (hi_ok && !shift_ff[0]) begin
          accept   = 1'b1;
          after_st = ST_ADDR_LO;
        end else if (hi_ok) begin
          // Read only after a prior full match
          accept   = prior_ff;
          after_st = ST_TX;
        end
      end
      ST_ADDR_LO: begin
        accept   = lo_ok;
        after_st = ST_RX;
      end
      ST_RX: begin
        accept   = 1'b1;
        after_st = ST_RX;
      end
      default: begin
        accept   = 1'b0;
        after_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (link_rst) begin
      state_ff    <= ST_IDLE;
      next_ff     <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      rx_hold_ff  <= 8'h00;
      sda_oe_ff   <= 1'b0;
      scl_oe_ff   <= 1'b0;
      hold_ff     <= 1'b0;
      nack_ff     <= 1'b0;
      prior_ff    <= 1'b0;
      rw_ff       <= 1'b0;
      ack_rcvd_ff <= 1'b0;
      ack_time_ff <= 1'b0;
      ev_ff       <= '0;
    end else begin
      ev_ff <= '0;
      if (start_det) begin
        // Restart resets slave logic like a Start
        ev_ff.start   <= ~busy_ff;
        ev_ff.restart <= busy_ff;
        state_ff      <= ST_ADDR_HI;
        bit_cnt_ff    <= 4'h0;
        sda_oe_ff     <= 1'b0;
        scl_oe_ff     <= 1'b0;
        hold_ff       <= 1'b0;
        ack_time_ff   <= 1'b0;
      end else if (stop_det) begin
        ev_ff.stop  <= 1'b1;
        state_ff    <= ST_IDLE;
        prior_ff    <= 1'b0;
        sda_oe_ff   <= 1'b0;
        scl_oe_ff   <= 1'b0;
        hold_ff     <= 1'b0;
        ack_time_ff <= 1'b0;
      end else if (hold_ff) begin
        // Software acknowledge value on clock release
        if (cmd_l[1]) begin
          scl_oe_ff <= 1'b0;
          hold_ff   <= 1'b0;
          nack_ff   <= nack_ff | cfg_l.ack_data;
          sda_oe_ff <= ~(nack_ff | cfg_l.ack_data);
        end
      end else if (state_ff == ST_TX_WAIT) begin
        if (cmd_l[0]) begin
          // Line already low before we drive
          if (tx_data_ff[7] && !sda_s) begin
            ev_ff.collision <= 1'b1;
            state_ff        <= ST_IDLE;
            scl_oe_ff       <= 1'b0;
          end else begin
            shift_ff   <= tx_data_ff;
            sda_oe_ff  <= ~tx_data_ff[7];
            scl_oe_ff  <= 1'b0;
            bit_cnt_ff <= 4'h0;
            state_ff   <= ST_TX;
          end
        end
      end else if (state_ff != ST_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt_ff != BYTE_END_COUNT) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (state_ff == ST_TX) begin
            if (bit_cnt_ff < ACK_BIT_COUNT && !sda_oe_ff && !sda_s) begin
              ev_ff.collision <= 1'b1;
              state_ff        <= ST_IDLE;
            end
            if (bit_cnt_ff == ACK_BIT_COUNT) begin
              ack_rcvd_ff <= sda_s;
            end
          end else if (bit_cnt_ff < ACK_BIT_COUNT) begin
            shift_ff <= {shift_ff[6:0], sda_s};
          end
        end else if (scl_fall) begin
          if (bit_cnt_ff == BYTE_END_COUNT) begin
            // Release data after the ninth pulse
            bit_cnt_ff  <= 4'h0;
            sda_oe_ff   <= 1'b0;
            ack_time_ff <= 1'b0;
            if (state_ff == ST_TX) begin
              if (ack_rcvd_ff) begin
                state_ff <= ST_IDLE;
              end else begin
                ev_ff.tx_req <= 1'b1;
                state_ff     <= ST_TX_WAIT;
                scl_oe_ff    <= 1'b1;
              end
            end else if (nack_ff) begin
              state_ff <= ST_IDLE;
            end else if (next_ff == ST_TX) begin
              state_ff  <= ST_TX_WAIT;
              scl_oe_ff <= 1'b1;
            end else begin
              state_ff <= next_ff;
            end
          end else if (state_ff == ST_TX) begin
            if (bit_cnt_ff == ACK_BIT_COUNT) begin
              sda_oe_ff <= 1'b0;
            end else if (bit_cnt_ff != 4'h0) begin
              shift_ff  <= {shift_ff[6:0], 1'b0};
              sda_oe_ff <= ~shift_ff[6];
            end
          end else if (bit_cnt_ff == ACK_BIT_COUNT) begin
            if (!accept) begin
              state_ff <= ST_IDLE;
              // Failed match in 10-bit mode clears prior match
              if (ten) begin
                prior_ff <= 1'b0;
              end
            end else begin
              if (state_ff == ST_ADDR_LO) begin
                prior_ff <= 1'b1;
              end else if (state_ff == ST_ADDR_HI && ten && !shift_ff[0]) begin
                prior_ff <= 1'b0;
              end
              if (state_ff == ST_ADDR_HI) begin
                rw_ff <= shift_ff[0];
              end
              // Hand the byte over with an interrupt
              ev_ff.rx_byte <= 1'b1;
              rx_hold_ff    <= shift_ff;
              next_ff       <= after_st;
              nack_ff       <= forced_nack;
              // Acknowledge time only with holds enabled
              ack_time_ff   <= cfg_l.addr_hold | cfg_l.data_hold;
              if (hold_now) begin
                scl_oe_ff <= 1'b1;
                hold_ff   <= 1'b1;
              end else begin
                sda_oe_ff <= ~forced_nack;
              end
            end
          end
        end
      end
    end
  end

  assign stat_l = '{ack_time:    ack_time_ff,
                    ack_rcvd:    ack_rcvd_ff,
                    idle:        idle_ff,
                    prior_match: prior_ff,
                    read_mode:   rw_ff};

  // Open-drain pins only ever pull low
  assign SCL_O    = 1'b0;
  assign SDA_O    = 1'b0;
  assign SCL_OE_O = scl_oe_ff;
  assign SDA_OE_O = sda_oe_ff;

  // ---------------- Core domain: software-facing state ----------------
  logic [7:0] rx_buf_ff;
  logic       irq_ff;
  logic       coll_ff;
  logic       start_seen_ff;
  logic       stop_seen_ff;
  logic       start_irq_on;
  logic       stop_irq_on;

  // Enable bits only add to modes lacking the interrupt
  assign start_irq_on = has_sp_irq(PORT_MODE_SELECT_I) | START_IRQ_ENABLE_I;
  assign stop_irq_on  = has_sp_irq(PORT_MODE_SELECT_I) | STOP_IRQ_ENABLE_I;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      tx_data_ff <= 8'h00;
    end else if (TX_LOAD_I) begin
      tx_data_ff <= TX_DATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      rx_buf_ff <= 8'h00;
      bf_ff     <= 1'b0;
      ov_ff     <= 1'b0;
    end else begin
      // Copy into the receive buffer; set wins over clear
      if (ev_c.rx_byte && !bf_ff && !ov_ff) begin
        rx_buf_ff <= rx_hold_ff;
        bf_ff     <= 1'b1;
      end else if (BUFFER_READ_I) begin
        bf_ff <= 1'b0;
      end
      if (ev_c.rx_byte && (bf_ff || ov_ff)) begin
        ov_ff <= 1'b1;
      end else if (OVERFLOW_CLEAR_I) begin
        ov_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      irq_ff        <= 1'b0;
      coll_ff       <= 1'b0;
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b0;
    end else begin
      if (ev_c.rx_byte || ev_c.tx_req || (start_irq_on && (ev_c.start || ev_c.restart)) ||
          (stop_irq_on && ev_c.stop)) begin
        irq_ff <= 1'b1;
      end else if (IRQ_FLAG_CLEAR_I) begin
        irq_ff <= 1'b0;
      end
      if (ev_c.collision) begin
        coll_ff <= 1'b1;
      end else if (COLLISION_CLEAR_I) begin
        coll_ff <= 1'b0;
      end
      if (ev_c.start || ev_c.restart) begin
        start_seen_ff <= 1'b1;
        stop_seen_ff  <= 1'b0;
      end else if (ev_c.stop) begin
        start_seen_ff <= 1'b0;
        stop_seen_ff  <= 1'b1;
      end
    end
  end

  assign RECEIVE_BUFFER_O        = rx_buf_ff;
  assign BUFFER_FULL_FLAG_O      = bf_ff;
  assign RECEIVE_OVERFLOW_FLAG_O = ov_ff;
  assign PORT_INTERRUPT_FLAG_O   = irq_ff;
  assign BUS_COLLISION_O         = coll_ff;
  assign START_SEEN_O            = start_seen_ff;
  assign STOP_SEEN_O             = stop_seen_ff;
  assign ACK_RECEIVED_STATUS_O   = stat_c.ack_rcvd;
  assign ACK_TIME_STATUS_O       = stat_c.ack_time;
  assign BUS_IDLE_O              = stat_c.idle;
  assign PRIOR_MATCH_O           = stat_c.prior_match;
  assign READ_NOT_WRITE_O        = stat_c.read_mode;

endmodule

// ===== rtl/iscaa_sync.sv
// Two-flop level synchroniser for a vector of quasi-static bits
`timescale 1ns/100ps
module iscaa_sync
  import iscaa_pkg::*;
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      q_o     <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule

// ===== test/iscaa_master.sv
// Behavioural bus master driving the open-drain clock and data lines
`timescale 1ns/100ps
module iscaa_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  localparam time HALF = 400ns;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // one clock pulse, waits out stretching
  task automatic bit_xfer(input logic b, output logic r);
    sda_low_o = !b;
    #HALF scl_low_o = 1'b0;
    while (!scl_i) #10;
    #HALF r = sda_i;
    scl_low_o = 1'b1;
  endtask
  task automatic start;
    sda_low_o = 1'b0;
    #HALF scl_low_o = 1'b0;
    #HALF sda_low_o = 1'b1;
    #HALF scl_low_o = 1'b1;
  endtask
  task automatic stop;
    sda_low_o = 1'b1;
    #HALF scl_low_o = 1'b0;
    #HALF sda_low_o = 1'b0;
    #HALF;
  endtask
  // Data dips with no clock low between
  task automatic blip;
    sda_low_o = 1'b1;
    #HALF sda_low_o = 1'b0;
    #HALF;
  endtask
  // eight bits MSB first then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(a, ack);
  endtask
endmodule

// ===== test/iscaa_slave_chk.sv
// Concurrent checks on the two-wire slave's flags and pins
`timescale 1ns/100ps
module iscaa_slave_chk
  import iscaa_pkg::*;
(
  input wire logic       CORE_CLK_I,
  input wire logic       SRST_I,
  input wire logic       LINK_CLK_I,
  input wire logic       SCL_I,
  input wire logic       SCL_O,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic       SCL_OE_O,
  input wire logic       BUS_IDLE_O,
  input wire logic [1:0] PORT_MODE_SELECT_I,
  input wire logic       BUFFER_READ_I,
  input wire logic       IRQ_FLAG_CLEAR_I,
  input wire logic       OVERFLOW_CLEAR_I,
  input wire logic [7:0] RECEIVE_BUFFER_O,
  input wire logic       BUFFER_FULL_FLAG_O,
  input wire logic       RECEIVE_OVERFLOW_FLAG_O,
  input wire logic       PORT_INTERRUPT_FLAG_O,
  input wire logic       START_SEEN_O,
  input wire logic       STOP_SEEN_O
);
  sequence s_irq_soon;
    ##[0:2] PORT_INTERRUPT_FLAG_O;
  endsequence
  a_pins_open_drain: assert property (@(posedge LINK_CLK_I) disable iff (SRST_I)
    SDA_OE_O || SCL_OE_O |-> !SDA_O && !SCL_O && !BUS_IDLE_O)
    else $error("pin driven while idle");
  a_data_clock_low: assert property (@(posedge LINK_CLK_I) disable iff (SRST_I)
    $changed(SDA_OE_O) |-> !SCL_I) else $error("data moved with clock high");
  a_irq_sticky: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    PORT_INTERRUPT_FLAG_O && !IRQ_FLAG_CLEAR_I |=> PORT_INTERRUPT_FLAG_O) else $error("irq lost");
  a_full_sticky: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BUFFER_FULL_FLAG_O && !BUFFER_READ_I |=> BUFFER_FULL_FLAG_O) else $error("full lost");
  a_ovf_sticky: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    RECEIVE_OVERFLOW_FLAG_O && !OVERFLOW_CLEAR_I |=> RECEIVE_OVERFLOW_FLAG_O)
    else $error("overflow lost");
  a_buffer_copy: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $changed(RECEIVE_BUFFER_O) |-> $rose(BUFFER_FULL_FLAG_O) && PORT_INTERRUPT_FLAG_O)
    else $error("buffer written without flags");
  a_start_irq: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $rose(START_SEEN_O) && PORT_MODE_SELECT_I[1] |-> s_irq_soon) else $error("no start irq");
  a_stop_irq: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $rose(STOP_SEEN_O) && PORT_MODE_SELECT_I[1] |-> s_irq_soon) else $error("no stop irq");
endmodule

bind iscaa_slave iscaa_slave_chk iscaa_slave_chk_inst (.CORE_CLK_I, .SRST_I, .LINK_CLK_I,
  .SCL_I, .SCL_O, .SDA_O, .SDA_OE_O, .SCL_OE_O, .BUS_IDLE_O, .PORT_MODE_SELECT_I,
  .BUFFER_READ_I, .IRQ_FLAG_CLEAR_I,
  .OVERFLOW_CLEAR_I, .RECEIVE_BUFFER_O, .BUFFER_FULL_FLAG_O, .RECEIVE_OVERFLOW_FLAG_O,
  .PORT_INTERRUPT_FLAG_O, .START_SEEN_O, .STOP_SEEN_O);

// ===== test/iscaa_slave_tb.sv
// Self-checking testbench of the two-wire slave
`timescale 1ns/100ps
module iscaa_slave_tb;
  import iscaa_pkg::*;
  logic       clk, lclk, rst, m_scl, m_sda, ack, sten, pten, rel, txl, clrs;
  logic       scl_oe, sda_oe, bf, ovf, irq, col, ss, ps, ackr, ackt, idle, prior, rnw;
  logic [7:0] q, txd, rbuf;
  iscaa_cfg_t cfg;
  int         mismatches, samples_checked, cycles;
  wire        scl = !(m_scl || scl_oe);
  wire        sda = !(m_sda || sda_oe);
  initial begin clk = 0; forever #12.5 clk = ~clk; end
  initial begin lclk = 0; #7; forever #24 lclk = ~lclk; end
  iscaa_master m (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
  iscaa_slave iscaa_slave_inst (.CORE_CLK_I(clk), .SRST_I(rst), .LINK_CLK_I(lclk),
    .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe),
    .PORT_MODE_SELECT_I(cfg.mode), .SLAVE_ADDRESS_I(cfg.addr), .SLAVE_ADDRESS_LOW_I(cfg.addr_lo),
    .ADDRESS_MASK_I(cfg.mask), .START_IRQ_ENABLE_I(sten), .STOP_IRQ_ENABLE_I(pten),
    .ADDRESS_HOLD_ENABLE_I(cfg.addr_hold), .DATA_HOLD_ENABLE_I(cfg.data_hold),
    .ACK_DATA_VALUE_I(cfg.ack_data), .RELEASE_CLOCK_I(rel), .TX_LOAD_I(txl), .TX_DATA_I(txd),
    .BUFFER_READ_I(clrs), .IRQ_FLAG_CLEAR_I(clrs), .OVERFLOW_CLEAR_I(clrs),
    .COLLISION_CLEAR_I(clrs), .RECEIVE_BUFFER_O(rbuf), .BUFFER_FULL_FLAG_O(bf),
    .RECEIVE_OVERFLOW_FLAG_O(ovf), .PORT_INTERRUPT_FLAG_O(irq), .BUS_COLLISION_O(col),
    .START_SEEN_O(ss), .STOP_SEEN_O(ps), .ACK_RECEIVED_STATUS_O(ackr),
    .ACK_TIME_STATUS_O(ackt), .BUS_IDLE_O(idle), .PRIOR_MATCH_O(prior), .READ_NOT_WRITE_O(rnw));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic clr;
    tick(1);
    clrs = 1'b1;
    tick(1);
    clrs = 1'b0;
    tick(4);
  endtask
  // Load a transmit byte only once the slave is stretching for it
  task automatic load(input logic [7:0] d);
    for (int i = 0; i < 800 && scl_oe !== 1'b1; i++) tick(1);
    chk(scl_oe, 1);
    txd = d;
    txl = 1'b1;
    tick(1);
    txl = 1'b0;
  endtask
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    {rst, sten, pten, rel, txl, clrs, txd} = {1'b1, 5'h00, 8'h00};
    cfg = '{mode: MODE_7BIT, addr: 8'ha4, mask: 8'hff, default: '0};
    tick(8);
    rst = 1'b0;
    tick(10);
    m.start; chk(idle, 0);
    m.xfer(8'ha4, 1, q, ack); chk(ack, 0);
    chk(rbuf, 8'ha4); chk(bf, 1);
    m.xfer(8'h3c, 1, q, ack); chk(ack, 1); chk(ovf, 1);
    chk(rbuf, 8'ha4);
    m.stop; tick(20); chk(idle, 1);
    clr; m.start; m.xfer(8'h24, 1, q, ack); chk(ack, 1);
    chk(irq, 0); chk(bf, 0); m.stop;
    cfg.addr = 8'ha5; cfg.mask = 8'hf1; clr;
    m.start; m.xfer(8'hac, 1, q, ack); chk(ack, 0); m.stop;
    cfg.addr = 8'ha4; cfg.mask = 8'hff;
    for (int i = 0; i < 8; i++) begin
      cfg.mode = i[1:0]; sten = i[2]; pten = i[2]; clr;
      m.start; chk(irq, i[1] | i[2]); chk(ss, 1); clr;
      m.stop; chk(irq, i[1] | i[2]); chk(ps, 1);
    end
    cfg.mode = MODE_7BIT_SP; sten = 0; pten = 0; clr;
    m.blip; tick(4); chk(ss, 1); chk(ps, 0);
    m.start; m.stop; cfg.mode = MODE_7BIT;
    cfg.addr_hold = 1; cfg.data_hold = 1; cfg.ack_data = 1; clr; m.start;
    fork
      m.xfer(8'ha4, 1, q, ack);
      begin
        for (int i = 0; i < 800 && ackt !== 1'b1; i++) tick(1);
        chk(ackt, 1); rel = 1; tick(1); rel = 0;
      end
    join
    chk(ack, 1); m.stop;
    cfg.addr_hold = 0; cfg.data_hold = 0; cfg.ack_data = 0;
    cfg.mode = MODE_10BIT; cfg.addr = 8'h06; cfg.addr_lo = 8'h5a; clr;
    m.start; m.xfer(8'hf6, 1, q, ack); chk(ack, 0);
    clr; m.xfer(8'h5a, 1, q, ack); chk(prior, 1);
    clr; m.start; m.xfer(8'hf7, 1, q, ack); chk(rnw, 1);
    load(8'h96);
    m.xfer(8'hff, 1, q, ack); chk(q, 8'h96);
    tick(8); chk(ackr, 1); chk(col, 0);
    clr; m.start; m.xfer(8'hf7, 1, q, ack); chk(ack, 0); load(8'h80);
    m.xfer(8'h7f, 1, q, ack); tick(8); chk(col, 1);
    m.stop; tick(8); chk(prior, 0);
    final_report;
  end
endmodule
